// ==== uart_sc_consts.svh ====
// Constants for the serial port status and control block
`ifndef UART_SC_CONSTS_SVH
`define UART_SC_CONSTS_SVH

// ==========================================
// Register indices on the plain register port
`define ADDR_STA  3'h0
`define ADDR_TXD  3'h1
`define ADDR_RXD  3'h2
`define ADDR_IST  3'h3
`define ADDR_IMSK 3'h4
`define ADDR_CFG  3'h5

// ==========================================
// Status and control field positions
`define B_TXISEL1 15
`define B_TXINV   14
`define B_TXISEL0 13
`define B_BRK     11
`define B_TXEN    10
`define B_RXISEL  7:6
`define B_ADDEN   5
`define B_RX_OVERRUN_FLAG    1

// ==========================================
// Reset values of writable fields
`define MODE_RST 2'h0
`define BIT_RST  1'b0

// ==========================================
// Interrupt mode encodings
`define TXI_ANY   2'h0
`define TXI_DONE  2'h1
`define TXI_EMPTY 2'h2
`define RXI_FULL  2'h3
`define RXI_3Q    2'h2

// ==========================================
// Interrupt status bit positions
`define EV_TX  0
`define EV_RX  1
`define EV_ERR 2

// ==========================================
// Queue levels and frame lengths
`define FIFO_DEPTH 3'h4
`define FIFO_3Q    3'h3
`define NORM_BITS  4'ha
`define BRK_BITS   4'he

// ==========================================
// Timing: bit time in ns, clock period in ns
`define CLK_NS   8
`define BIT_NS   128
`define BIT_CYC  8'((`BIT_NS) / (`CLK_NS))
`define HALF_CYC 8'((`BIT_NS) / (2 * `CLK_NS))
`define IR_CYC   8'((`BIT_NS * 3) / (16 * `CLK_NS))

`endif

// ==== uart_sc_pkg.sv ====
// Types shared by the serial port status and control block
`default_nettype none
package uart_sc_pkg;
  typedef enum logic [1:0] {TX_IDLE = 2'b00, TX_RUN = 2'b01} tx_state_t;
  typedef enum logic [1:0] {
    RX_IDLE = 2'b00, RX_START = 2'b01, RX_DATA = 2'b11, RX_STOP = 2'b10
  } rx_state_t;
endpackage : uart_sc_pkg
`default_nettype wire

// ==== char_fifo.sv ====
// Four-entry character queue held in flip-flops
`include "uart_sc_consts.svh"
`default_nettype none
module char_fifo #(
  parameter int W = 8
) (
  input  wire logic         core_clk,
  input  wire logic         rst_b,
  input  wire logic         flush,
  input  wire logic         push,
  input  wire logic [W-1:0] din,
  input  wire logic         pop,
  output logic      [W-1:0] dout,
  output logic      [2:0]   count
);
  logic [W-1:0] mem [0:3];
  logic [1:0]   rp;
  logic [1:0]   wp;
  logic [1:0]   next_rp;
  logic [1:0]   next_wp;
  logic [2:0]   next_count;
  logic         do_push;
  logic         do_pop;

  // ==========================================
  // Pointers; push refused when full, pop when empty
  always_comb begin
    do_push    = push && (count != `FIFO_DEPTH) && !flush;
    do_pop     = pop && (count != 3'h0) && !flush;
    next_rp    = rp + {1'b0, do_pop};
    next_wp    = wp + {1'b0, do_push};
    next_count = count + {2'h0, do_push} - {2'h0, do_pop};
    if (flush) begin
      next_rp    = 2'h0;
      next_wp    = 2'h0;
      next_count = 3'h0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rp    <= 2'h0;
      wp    <= 2'h0;
      count <= 3'h0;
    end else begin
      rp    <= next_rp;
      wp    <= next_wp;
      count <= next_count;
    end
  end

  // Storage needs no reset; dout shows mem[rp] even when the queue is empty
  always_ff @(posedge core_clk) begin
    if (do_push) begin
      mem[wp] <= din;
    end
  end

  assign dout = mem[rp];
endmodule : char_fifo
`default_nettype wire

// ==== uart_status_control.sv ====
// Serial port status and control register with transmitter and receiver
// Operation
// - Transmit interrupt mode picks transmit event
// - Plain mode: invert bit gives idle low
// - Infrared mode: encoded, invert gives idle high
// - Break request sends start, twelve zeros, stop
// - Enable drives pin; clearing aborts, flushes
// - Buffer full flag reads one when full
// - Shifter empty only when both stages empty
// - Receive mode picks one, three, four characters
// - Receive mode field bits 7-6, resets 00
//
// The strobed register port and the placing of the registers are this design's own decisions.
`include "uart_sc_consts.svh"
`default_nettype none
module uart_status_control
  import uart_sc_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rst_b,
  input  wire logic [2:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  input  wire logic        serial_rx_pin,
  output logic             serial_tx_pin,
  output logic             serial_tx_oe_b,
  output logic             irq
);
  // ==========================================
  // Register fields
  logic [1:0]  tx_irq_mode, next_tx_irq_mode;
  logic        tx_polarity_invert, next_tx_polarity_invert;
  logic        tx_break_request, next_tx_break_request;
  logic        tx_enable_bit, next_tx_enable_bit;
  logic [1:0]  rx_irq_mode, next_rx_irq_mode;
  logic        addr_detect, next_addr_detect;
  logic        rx_overrun_flag, next_rx_overrun_flag;
  logic        framing_error_flag, next_framing_error_flag;
  logic        infrared_encode_on, next_infrared_encode_on;
  logic [2:0]  irq_status, next_irq_status;
  logic [2:0]  irq_mask, next_irq_mask;
  logic [15:0] next_reg_rdata;
  logic        next_irq;
  // Decoded strobes and status terms
  logic        wr_sta, wr_txd, rd_rxd, wr_ist, wr_msk, wr_cfg;
  logic        tx_buffer_full, tx_shifter_empty, rx_idle_flag;
  logic        rx_data_available, parity_error_flag;
  logic [15:0] sta_word;
  // Transmitter
  tx_state_t   tx_state, next_tx_state;
  logic [13:0] tx_sh, next_tx_sh;
  logic [3:0]  tx_left, next_tx_left;
  logic [7:0]  tx_cyc, next_tx_cyc;
  logic        tx_brk_run, next_tx_brk_run;
  logic        next_serial_tx_pin, next_serial_tx_oe_b;
  logic        tx_xfer, tx_done, brk_start, tx_bit, ir_pulse, tx_ev;
  logic [7:0]  tx_head;
  logic [2:0]  tx_cnt;
  // Receiver
  rx_state_t   rx_state, next_rx_state;
  logic        rx_s1, rx_s2, rx_s3, rx_line, next_rx_line;
  logic [7:0]  rx_shift_reg, next_rx_shift_reg;
  logic [7:0]  rx_cyc, next_rx_cyc;
  logic [3:0]  rx_bits, next_rx_bits;
  logic        rx_frame, rx_push, rx_ev, err_ev;
  logic [7:0]  rx_head;
  logic [2:0]  rx_cnt;

  // ==========================================
  // Address decode
  always_comb begin
    wr_sta = 1'b0;
    wr_txd = 1'b0;
    rd_rxd = 1'b0;
    wr_ist = 1'b0;
    wr_msk = 1'b0;
    wr_cfg = 1'b0;
    if (reg_addr == `ADDR_STA) begin
      wr_sta = reg_wr;
    end else if (reg_addr == `ADDR_TXD) begin
      wr_txd = reg_wr;
    end else if (reg_addr == `ADDR_RXD) begin
      rd_rxd = reg_rd;
    end else if (reg_addr == `ADDR_IST) begin
      wr_ist = reg_wr;
    end else if (reg_addr == `ADDR_IMSK) begin
      wr_msk = reg_wr;
    end else if (reg_addr == `ADDR_CFG) begin
      wr_cfg = reg_wr;
    end
  end

  // ==========================================
  // Character queues; a disabled transmitter holds its queue flushed
  char_fifo #(.W(8)) u_tx_fifo (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .flush    (!tx_enable_bit),
    .push     (wr_txd),
    .din      (reg_wdata[7:0]),
    .pop      (tx_xfer),
    .dout     (tx_head),
    .count    (tx_cnt)
  );

  char_fifo #(.W(8)) u_rx_fifo (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .flush    (1'b0),
    .push     (rx_push),
    .din      (rx_shift_reg),
    .pop      (rd_rxd),
    .dout     (rx_head),
    .count    (rx_cnt)
  );

  // Status terms seen by software
  assign tx_buffer_full    = (tx_cnt == `FIFO_DEPTH);
  assign tx_shifter_empty  = (tx_state == TX_IDLE) && (tx_cnt == 3'h0);
  assign rx_data_available = (rx_cnt != 3'h0);
  assign rx_idle_flag      = (rx_state == RX_IDLE);
  assign parity_error_flag = 1'b0; // No parity in 8N1 framing

  // ==========================================
  // Transmitter: break takes precedence over queued data
  always_comb begin
    next_tx_state   = tx_state;
    next_tx_sh      = tx_sh;
    next_tx_left    = tx_left;
    next_tx_cyc     = tx_cyc;
    next_tx_brk_run = tx_brk_run;
    tx_xfer         = 1'b0;
    tx_done         = 1'b0;
    brk_start       = 1'b0;
    case (tx_state)
      TX_IDLE: begin
        if (tx_enable_bit && tx_break_request) begin
          brk_start       = 1'b1;
          next_tx_sh      = {1'b1, 12'h000, 1'b0};
          next_tx_left    = `BRK_BITS;
          next_tx_cyc     = 8'h00;
          next_tx_brk_run = 1'b1;
          next_tx_state   = TX_RUN;
        end else if (tx_enable_bit && (tx_cnt != 3'h0)) begin
          tx_xfer         = 1'b1;
          next_tx_sh      = {5'h1f, tx_head, 1'b0};
          next_tx_left    = `NORM_BITS;
          next_tx_cyc     = 8'h00;
          next_tx_brk_run = 1'b0;
          next_tx_state   = TX_RUN;
        end
      end
      TX_RUN: begin
        if (tx_cyc == `BIT_CYC - 8'h01) begin
          next_tx_cyc  = 8'h00;
          next_tx_sh   = {1'b1, tx_sh[13:1]};
          next_tx_left = tx_left - 4'h1;
          if (tx_left == 4'h1) begin
            tx_done       = 1'b1;
            next_tx_state = TX_IDLE;
          end
        end else begin
          next_tx_cyc = tx_cyc + 8'h01;
        end
      end
      default: next_tx_state = TX_IDLE;
    endcase
    // Abort the frame in flight when disabled
    if (!tx_enable_bit) begin
      next_tx_state   = TX_IDLE;
      next_tx_left    = 4'h0;
      next_tx_cyc     = 8'h00;
      next_tx_brk_run = 1'b0;
    end
    tx_bit   = (tx_state == TX_RUN) ? tx_sh[0] : 1'b1;
    // Short pulse marks each zero bit on the infrared line
    ir_pulse = !tx_bit && (tx_cyc < `IR_CYC);
    if (infrared_encode_on) begin
      next_serial_tx_pin = ir_pulse ^ tx_polarity_invert;
    end else begin
      next_serial_tx_pin = tx_bit ^ tx_polarity_invert;
    end
    next_serial_tx_oe_b = !tx_enable_bit;
    case (tx_irq_mode)
      `TXI_ANY:   tx_ev = tx_xfer;
      `TXI_EMPTY: tx_ev = tx_xfer && (tx_cnt == 3'h1);
      `TXI_DONE:  tx_ev = tx_done && (tx_cnt == 3'h0);
      default:    tx_ev = 1'b0;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_state       <= TX_IDLE;
      tx_sh          <= 14'h3fff;
      tx_left        <= 4'h0;
      tx_cyc         <= 8'h00;
      tx_brk_run     <= 1'b0;
      serial_tx_pin  <= 1'b1;
      serial_tx_oe_b <= 1'b1;
    end else begin
      tx_state       <= next_tx_state;
      tx_sh          <= next_tx_sh;
      tx_left        <= next_tx_left;
      tx_cyc         <= next_tx_cyc;
      tx_brk_run     <= next_tx_brk_run;
      serial_tx_pin  <= next_serial_tx_pin;
      serial_tx_oe_b <= next_serial_tx_oe_b;
    end
  end

  // ==========================================
  // Receiver: line change counts once stages two and three agree
  always_comb begin
    next_rx_line      = (rx_s2 == rx_s3) ? rx_s3 : rx_line;
    next_rx_state     = rx_state;
    next_rx_shift_reg = rx_shift_reg;
    next_rx_cyc       = rx_cyc + 8'h01;
    next_rx_bits      = rx_bits;
    rx_frame          = 1'b0;
    case (rx_state)
      RX_IDLE: begin
        next_rx_cyc = 8'h00;
        if (!rx_line) begin
          next_rx_state = RX_START;
        end
      end
      RX_START: begin
        if (rx_cyc == `HALF_CYC - 8'h01) begin
          next_rx_cyc   = 8'h00;
          next_rx_bits  = 4'h0;
          next_rx_state = rx_line ? RX_IDLE : RX_DATA; // Glitch rejected
        end
      end
      RX_DATA: begin
        if (rx_cyc == `BIT_CYC - 8'h01) begin
          next_rx_cyc       = 8'h00;
          next_rx_shift_reg = {rx_line, rx_shift_reg[7:1]};
          next_rx_bits      = rx_bits + 4'h1;
          if (rx_bits == 4'h7) begin
            next_rx_state = RX_STOP;
          end
        end
      end
      RX_STOP: begin
        if (rx_cyc == `BIT_CYC - 8'h01) begin
          rx_frame      = 1'b1;
          next_rx_state = RX_IDLE;
        end
      end
      default: next_rx_state = RX_IDLE;
    endcase
    // A full queue drops the new character
    rx_push = rx_frame && (rx_cnt != `FIFO_DEPTH);
    err_ev  = rx_frame && (!rx_line || (rx_cnt == `FIFO_DEPTH));
    case (rx_irq_mode)
      `RXI_FULL: rx_ev = rx_push && ((rx_cnt + 3'h1) == `FIFO_DEPTH);
      `RXI_3Q:   rx_ev = rx_push && ((rx_cnt + 3'h1) == `FIFO_3Q);
      default:   rx_ev = rx_push;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_s1        <= 1'b1;
      rx_s2        <= 1'b1;
      rx_s3        <= 1'b1;
      rx_line      <= 1'b1;
      rx_state     <= RX_IDLE;
      rx_shift_reg <= 8'h00;
      rx_cyc       <= 8'h00;
      rx_bits      <= 4'h0;
    end else begin
      rx_s1        <= serial_rx_pin;
      rx_s2        <= rx_s1;
      rx_s3        <= rx_s2;
      rx_line      <= next_rx_line;
      rx_state     <= next_rx_state;
      rx_shift_reg <= next_rx_shift_reg;
      rx_cyc       <= next_rx_cyc;
      rx_bits      <= next_rx_bits;
    end
  end

  // ==========================================
  // Registers, interrupt and read data
  assign sta_word = {tx_irq_mode[1], tx_polarity_invert, tx_irq_mode[0], 1'b0,
                     tx_break_request, tx_enable_bit, tx_buffer_full, tx_shifter_empty,
                     rx_irq_mode, addr_detect, rx_idle_flag, parity_error_flag,
                     framing_error_flag, rx_overrun_flag, rx_data_available};

  always_comb begin
    next_tx_irq_mode        = tx_irq_mode;
    next_tx_polarity_invert = tx_polarity_invert;
    next_tx_break_request   = tx_break_request;
    next_tx_enable_bit      = tx_enable_bit;
    next_rx_irq_mode        = rx_irq_mode;
    next_addr_detect        = addr_detect;
    next_infrared_encode_on = infrared_encode_on;
    if (tx_done && tx_brk_run) begin
      next_tx_break_request = 1'b0;
    end
    if (wr_sta) begin
      next_tx_irq_mode        = {reg_wdata[`B_TXISEL1], reg_wdata[`B_TXISEL0]};
      next_tx_polarity_invert = reg_wdata[`B_TXINV];
      next_tx_break_request   = reg_wdata[`B_BRK];
      next_tx_enable_bit      = reg_wdata[`B_TXEN];
      next_rx_irq_mode        = reg_wdata[`B_RXISEL];
      next_addr_detect        = reg_wdata[`B_ADDEN];
    end
    if (wr_cfg) begin
      next_infrared_encode_on = reg_wdata[0];
    end
    // Hardware set wins over a software clear in the same cycle
    next_rx_overrun_flag = (rx_frame && (rx_cnt == `FIFO_DEPTH)) ||
                           (rx_overrun_flag && !(wr_sta && !reg_wdata[`B_RX_OVERRUN_FLAG]));
    next_framing_error_flag = rx_frame ? !rx_line : framing_error_flag;
    next_irq_status = (irq_status & ~(wr_ist ? reg_wdata[2:0] : 3'h0)) | {err_ev, rx_ev, tx_ev};
    next_irq_mask   = wr_msk ? reg_wdata[2:0] : irq_mask;
    next_irq        = |(next_irq_status & next_irq_mask);
    next_reg_rdata  = 16'h0000;
    if (reg_rd) begin
      if (reg_addr == `ADDR_STA) begin
        next_reg_rdata = sta_word;
      end else if (reg_addr == `ADDR_RXD) begin
        next_reg_rdata = {8'h00, rx_head};
      end else if (reg_addr == `ADDR_IST) begin
        next_reg_rdata = {13'h0000, irq_status};
      end else if (reg_addr == `ADDR_IMSK) begin
        next_reg_rdata = {13'h0000, irq_mask};
      end else if (reg_addr == `ADDR_CFG) begin
        next_reg_rdata = {15'h0000, infrared_encode_on};
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_irq_mode        <= `MODE_RST;
      tx_polarity_invert <= `BIT_RST;
      tx_break_request   <= `BIT_RST;
      tx_enable_bit      <= `BIT_RST;
      rx_irq_mode        <= `MODE_RST;
      addr_detect        <= `BIT_RST;
      rx_overrun_flag    <= `BIT_RST;
      framing_error_flag <= `BIT_RST;
      infrared_encode_on <= `BIT_RST;
      irq_status         <= 3'h0;
      irq_mask           <= 3'h0;
      irq                <= 1'b0;
      reg_rdata          <= 16'h0000;
    end else begin
      tx_irq_mode        <= next_tx_irq_mode;
      tx_polarity_invert <= next_tx_polarity_invert;
      tx_break_request   <= next_tx_break_request;
      tx_enable_bit      <= next_tx_enable_bit;
      rx_irq_mode        <= next_rx_irq_mode;
      addr_detect        <= next_addr_detect;
      rx_overrun_flag    <= next_rx_overrun_flag;
      framing_error_flag <= next_framing_error_flag;
      infrared_encode_on <= next_infrared_encode_on;
      irq_status         <= next_irq_status;
      irq_mask           <= next_irq_mask;
      irq                <= next_irq;
      reg_rdata          <= next_reg_rdata;
    end
  end

  // ==========================================
  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  property p_tx_irq_done;
    tx_irq_mode == `TXI_DONE && tx_done && tx_cnt == 3'h0 |=> irq_status[`EV_TX];
  endproperty
  a_tx_irq_done: assert property (p_tx_irq_done) else $error("last-char irq missed");
  property p_idle_plain;
    tx_enable_bit && !infrared_encode_on && tx_state == TX_IDLE
      |=> serial_tx_pin == !$past(tx_polarity_invert);
  endproperty
  a_idle_plain: assert property (p_idle_plain) else $error("plain idle level wrong");
  property p_idle_ir;
    tx_enable_bit && infrared_encode_on && tx_state == TX_IDLE
      |=> serial_tx_pin == $past(tx_polarity_invert);
  endproperty
  a_idle_ir: assert property (p_idle_ir) else $error("infrared idle level wrong");
  property p_brk_zero;
    tx_brk_run && tx_state == TX_RUN && tx_left > 4'h1 |-> !tx_bit;
  endproperty
  a_brk_zero: assert property (p_brk_zero) else $error("break bit not zero");
  property p_brk_clr;
    tx_done && tx_brk_run && !wr_sta |=> !tx_break_request;
  endproperty
  a_brk_clr: assert property (p_brk_clr) else $error("break request not cleared");
  property p_abort;
    !tx_enable_bit |=> serial_tx_oe_b && tx_cnt == 3'h0 && tx_state == TX_IDLE;
  endproperty
  a_abort: assert property (p_abort) else $error("disable did not abort");
  property p_tx_full;
    tx_buffer_full && wr_txd && !tx_xfer |=> tx_cnt == `FIFO_DEPTH && tx_buffer_full;
  endproperty
  a_tx_full: assert property (p_tx_full) else $error("full flag or level wrong");
  property p_tx_shifter_empty;
    wr_txd && tx_enable_bit |=> !tx_shifter_empty;
  endproperty
  a_tx_shifter_empty: assert property (p_tx_shifter_empty) else $error("shifter empty with data queued");
  property p_rx_full_irq;
    rx_irq_mode == `RXI_FULL && rx_push && rx_cnt == `FIFO_3Q |=> irq_status[`EV_RX];
  endproperty
  a_rx_full_irq: assert property (p_rx_full_irq) else $error("full irq missed");
  property p_rx_mode;
    wr_sta |=> rx_irq_mode == $past(reg_wdata[7:6]);
  endproperty
  a_rx_mode: assert property (p_rx_mode) else $error("rx mode write lost");
  property p_overrun;
    rx_frame && rx_cnt == `FIFO_DEPTH |=> rx_overrun_flag;
  endproperty
  a_overrun: assert property (p_overrun) else $error("overrun not flagged");
  property p_rx_avail;
    rx_push |=> rx_data_available;
  endproperty
  a_rx_avail: assert property (p_rx_avail) else $error("data available not set");

  c_break: cover property (tx_done && tx_brk_run);
  c_overrun: cover property (rx_frame && rx_cnt == `FIFO_DEPTH);
  c_framing_error_flag: cover property (rx_frame && !rx_line);
  c_ir_tx: cover property (infrared_encode_on && tx_xfer);
endmodule : uart_status_control
`default_nettype wire

// ==== remote_serial.sv ====
// Remote serial transmitter and receiver facing the port
`default_nettype none
module remote_serial (
  input  wire logic core_clk,
  input  wire logic serial_tx_pin,
  output logic      serial_rx_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================
  // Line idles high between frames
  initial serial_rx_pin = 1'b1;
  // Start, eight bits LSB first, stop; 16 cycles a bit
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(negedge core_clk) serial_rx_pin = f[i];
      repeat (15) @(negedge core_clk);
    end
  endtask : send
  // Bounded so a dead line cannot hang the run
  task automatic wait_low();
    for (int w = 0; w < 600 && serial_tx_pin !== 1'b0; w++) @(negedge core_clk);
  endtask : wait_low
  // Length in cycles of the next low run
  task automatic low_run(output int n);
    wait_low();
    for (n = 0; n < 600 && serial_tx_pin === 1'b0; n++) @(negedge core_clk);
  endtask : low_run
  // Bits sampled mid-bit, returns inside the stop bit
  task automatic get(output logic [7:0] b);
    wait_low();
    repeat (8) @(negedge core_clk);
    for (int i = 0; i < 9; i++) begin
      repeat (16) @(negedge core_clk);
      if (i < 8) b[i] = serial_tx_pin;
    end
  endtask : get
endmodule : remote_serial
`default_nettype wire

// ==== testbench.sv ====
// Self-checking bench for the serial status and control block
`include "uart_sc_consts.svh"
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        core_clk;
  logic        rst_b;
  logic [2:0]  reg_addr;
  logic [15:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [15:0] reg_rdata;
  logic        serial_rx_pin;
  logic        serial_tx_pin;
  logic        serial_tx_oe_b;
  logic        irq;
  int          fail_count;
  int          check_count;
  int          n;
  logic [15:0] d;
  logic [7:0]  b;
  logic [7:0]  got;
  logic [7:0]  q[$];

  uart_status_control dut (.core_clk(core_clk), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .serial_rx_pin(serial_rx_pin), .serial_tx_pin(serial_tx_pin),
    .serial_tx_oe_b(serial_tx_oe_b), .irq(irq));
  remote_serial peer (.core_clk(core_clk), .serial_tx_pin(serial_tx_pin),
    .serial_rx_pin(serial_rx_pin));

  // ==========================================
  // Bus cycles, compare and verdict
  task automatic wr(input logic [2:0] a, input logic [15:0] v);
    @(posedge core_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= v;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr
  // Data stands only in the cycle after the read edge
  task automatic rd(input logic [2:0] a, output logic [15:0] v);
    @(posedge core_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask : rd
  task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e) begin
      fail_count++;
      $display("FAIL %s expected %h seen %h", what, e, g);
    end
  endtask : chk
  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : end_sim
  // Sticky receive event after c characters
  function automatic logic rx_ev(input logic [1:0] m, input int c);
    return (m == `RXI_FULL) ? c >= 4 : (m == `RXI_3Q) ? c >= 3 : c >= 1;
  endfunction : rx_ev
  // Done-mode fires only once the frame has ended
  function automatic logic tx_ev(input logic [1:0] m, input logic done);
    return (m == `TXI_DONE) ? done : 1'b1;
  endfunction : tx_ev

  // ==========================================
  // Clock and watchdog
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  initial begin
    repeat (30000) @(posedge core_clk);
    fail_count++;
    end_sim();
  end

  // ==========================================
  // Main sequence
  initial begin
    rst_b = 1'b0;
    reg_addr = 3'h0;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    void'($urandom(93578));
    repeat (20) @(posedge core_clk);
    rst_b <= 1'b1;
    // Reset word, read-only bits ignore writes, unmapped index
    rd(`ADDR_STA, d);
    chk("reset status", 16'h0110, d);
    wr(`ADDR_STA, 16'h031d);
    rd(`ADDR_STA, d);
    chk("ro flags", 16'h0110, d & 16'h031d);
    rd(3'h6, d);
    chk("unmapped", 16'h0000, d);
    // Transmit interrupt modes with a random character each
    for (int m = 0; m < 3; m++) begin
      wr(`ADDR_STA, {m[1], 1'b0, m[0], 2'b00, 1'b1, 10'h000});
      wr(`ADDR_IST, 16'h0007);
      b = 8'($urandom);
      fork
        peer.get(got);
        begin
          wr(`ADDR_TXD, {8'h00, b});
          repeat (4) @(posedge core_clk);
          rd(`ADDR_IST, d);
          chk("tx ev early", {15'h0, tx_ev(2'(m), 1'b0)}, {15'h0, d[`EV_TX]});
        end
      join
      chk("tx byte", {8'h00, b}, {8'h00, got});
      repeat (16) @(posedge core_clk);
      rd(`ADDR_IST, d);
      chk("tx ev late", {15'h0, tx_ev(2'(m), 1'b1)}, {15'h0, d[`EV_TX]});
    end
    // Break ahead of a queued character
    fork
      peer.low_run(n);
      begin
        wr(`ADDR_STA, 16'h0c00);
        wr(`ADDR_TXD, 16'h00ff);
      end
    join
    chk("break low", 16'd208, 16'(n));
    repeat (200) @(posedge core_clk);
    rd(`ADDR_STA, d);
    chk("break clr", 16'h0100, d & 16'h0900);
    // Idle level over polarity and infrared settings
    for (int k = 0; k < 4; k++) begin
      wr(`ADDR_CFG, {15'h0, k[1]});
      wr(`ADDR_STA, {1'b0, k[0], 4'h1, 10'h000});
      repeat (4) @(posedge core_clk);
      chk("idle", {15'h0, k[0] ~^ k[1]}, {15'h0, serial_tx_pin});
      chk("oe on", 16'h0, {15'h0, serial_tx_oe_b});
    end
    // Fill until full, then abort by disabling
    wr(`ADDR_CFG, 16'h0000);
    wr(`ADDR_STA, 16'h0400);
    for (int k = 0; k < 5; k++) wr(`ADDR_TXD, 16'($urandom_range(255)));
    rd(`ADDR_STA, d);
    chk("full", 16'h0200, d & 16'h0300);
    wr(`ADDR_STA, 16'h0000);
    rd(`ADDR_STA, d);
    chk("aborted", 16'h0100, d & 16'h0300);
    chk("oe off", 16'h1, {15'h0, serial_tx_oe_b});
    // Receive thresholds for every mode
    for (int m = 0; m < 4; m++) begin
      wr(`ADDR_STA, {8'h00, 2'(m), 6'h00});
      wr(`ADDR_IST, 16'h0007);
      rd(`ADDR_STA, d);
      chk("rx mode", 16'(m), {14'h0, d[`B_RXISEL]});
      for (int c = 1; c <= 4; c++) begin
        b = 8'($urandom);
        q.push_back(b);
        peer.send(b);
        repeat (4) @(posedge core_clk);
        rd(`ADDR_IST, d);
        chk("rx ev", {15'h0, rx_ev(2'(m), c)}, {15'h0, d[`EV_RX]});
      end
      rd(`ADDR_STA, d);
      chk("avail", 16'h1, {15'h0, d[0]});
      for (int c = 0; c < 4; c++) begin
        rd(`ADDR_RXD, d);
        chk("rx byte", {8'h00, q.pop_front()}, {8'h00, d[7:0]});
      end
      rd(`ADDR_STA, d);
      chk("drained", 16'h0, {15'h0, d[0]});
    end
    // Overrun, masked then unmasked error interrupt
    wr(`ADDR_STA, 16'h0000);
    wr(`ADDR_IST, 16'h0007);
    for (int c = 0; c < 5; c++) peer.send(8'($urandom));
    rd(`ADDR_STA, d);
    chk("overrun", 16'h0002, d & 16'h0002);
    chk("irq masked", 16'h0, {15'h0, irq});
    wr(`ADDR_IMSK, 16'h0004);
    @(posedge core_clk);
    chk("irq up", 16'h1, {15'h0, irq});
    wr(`ADDR_STA, 16'h0002);
    wr(`ADDR_STA, 16'h0000);
    rd(`ADDR_STA, d);
    chk("ovr clr", 16'h0000, d & 16'h0002);
    wr(`ADDR_IST, 16'h0004);
    @(posedge core_clk);
    chk("irq down", 16'h0, {15'h0, irq});
    end_sim();
  end
endmodule : testbench
`default_nettype wire
